// file: rsc_cfg.svh
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

`define RSC_ADDR_W 8
`define RSC_DATA_W 32
`define RSC_REG_STATUS 8'h00
`define RSC_REG_CTRL 8'h04
`define RSC_REG_SOURCE 8'h08

`define RSC_ST_BOOT0 0
`define RSC_ST_BOOT1 1
`define RSC_ST_WKP 2
`define RSC_ST_XTAL 3
`define RSC_ST_DBGEN 4
`define RSC_ST_OSCOK 5
`define RSC_ST_INRST 6
`define RSC_CT_SWRST 0
`define RSC_CT_BKPT 1
`define RSC_SRC_LO 0
`define RSC_SRC_HI 1

`define RSC_WKP_LEAD 4
`define RSC_HOLD_CYCLES 32
`define RSC_TRACE0_RST 1'b1
`define RSC_PULL_RST 1'b0
`define RSC_XTAL_RST 1'b0
`define RSC_DBGEN_RST 1'b0

`endif

// file: rsc_pkg.sv
package rsc_pkg;

    typedef struct packed {
        logic osc_ref_select_strap;
        logic reset_cfg_select;
        logic debug_event_in;
        logic [0:1] boot_select_strap;
        logic weak_pull_select_strap;
    } rsc_straps_s;

    typedef enum logic [1:0] {
        RSC_BOOT_FLASH,
        RSC_BOOT_SERIAL,
        RSC_BOOT_EXTMEM,
        RSC_BOOT_RSVD
    } rsc_boot_e;

    typedef enum logic [1:0] {
        RSC_SRC_POR,
        RSC_SRC_EXT,
        RSC_SRC_DBG,
        RSC_SRC_SWEXT
    } rsc_src_e;

    typedef enum logic [1:0] {
        RSC_PH_ASSERT,
        RSC_PH_HELD,
        RSC_PH_RUN
    } rsc_phase_e;

    function automatic rsc_boot_e rsc_boot_decode(input logic [0:1] cfg);
        rsc_boot_e mode;
        mode = rsc_boot_e'({cfg[0], cfg[1]});
        return mode;
    endfunction : rsc_boot_decode

endpackage : rsc_pkg

// file: rsc_pin_sync.sv
`timescale 1ns/1ps
module rsc_pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_d;
    logic [W-1:0] out_q;

    // A bit moves only where stages two and three agree
    always_comb begin
        out_d = (s3_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else if (clk_en) begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule : rsc_pin_sync

// file: rsc_reset_timer.sv
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_reset_timer #(
    parameter int HOLD = `RSC_HOLD_CYCLES,
    parameter int LEAD = `RSC_WKP_LEAD
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic start,
    output logic active,
    output logic lead_hit,
    output logic last
);
    localparam int CW = $clog2(HOLD + 1);
    localparam logic [CW-1:0] LOAD = CW'(HOLD - 1);
    // Pin negates two edges after count zero, so aim one count lower
    localparam logic [CW-1:0] LEAD_CNT = CW'(LEAD - 1);

    logic [CW-1:0] cnt_d;
    logic [CW-1:0] cnt_q;
    logic act_d;
    logic act_q;

    always_comb begin
        cnt_d = cnt_q;
        act_d = act_q;
        if (act_q) begin
            if (cnt_q == '0) begin
                act_d = 1'b0;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end else if (start) begin
            act_d = 1'b1;
            cnt_d = LOAD;
        end
    end

    // Power-on starts a full reset sequence
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            act_q <= 1'b1;
            cnt_q <= LOAD;
        end else if (clk_en) begin
            act_q <= act_d;
            cnt_q <= cnt_d;
        end
    end

    assign active = act_q;
    assign lead_hit = act_q && (cnt_q == LEAD_CNT);
    assign last = act_q && (cnt_q == '0);
endmodule : rsc_reset_timer

// file: rsc_top.sv
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_top #(
    parameter bit LARGE_PKG = 1'b1,
    parameter bit HAS_EXT_BUS = 1'b1,
    parameter int RST_HOLD_CYCLES = `RSC_HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input rsc_pkg::rsc_straps_s strap_pins,
    input wire logic ext_reset_req_pin,
    input wire logic osc_stable_in,
    input wire logic debug_reset_req,
    input wire logic [`RSC_ADDR_W-1:0] addr,
    input wire logic [`RSC_DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [`RSC_DATA_W-1:0] rd_data,
    output logic reset_output_pin,
    output logic osc_xtal_mode,
    output rsc_pkg::rsc_boot_e boot_mode,
    output logic cfg_word_ext,
    output logic pad_pull_up,
    output logic debug_port_en,
    output logic sync_msg_req,
    output logic breakpoint_req,
    output logic trace_msg0_out
);
    import rsc_pkg::*;

    localparam int SW = $bits(rsc_straps_s);

    rsc_straps_s straps;
    logic [SW-1:0] straps_raw;
    logic [1:0] misc_sync;
    logic ext_req;
    logic osc_ok;
    logic t_active;
    logic t_lead;
    logic t_last;
    logic t_start;
    logic [0:1] boot_eff;

    rsc_phase_e phase_d;
    rsc_phase_e phase_q;
    rsc_src_e src_d;
    rsc_src_e src_q;
    logic wkp_lat_d;
    logic wkp_lat_q;
    logic wkp_rsr_d;
    logic wkp_rsr_q;
    logic [0:1] boot_lat_d;
    logic [0:1] boot_lat_q;
    logic xtal_d;
    logic xtal_q;
    logic dbg_en_d;
    logic dbg_en_q;
    logic pull_d;
    logic pull_q;
    logic trace0_d;
    logic trace0_q;
    rsc_boot_e mode_d;
    rsc_boot_e mode_q;
    logic cfgw_d;
    logic cfgw_q;
    logic rst_out_d;
    logic rst_out_q;

    logic evt_prev_d;
    logic evt_prev_q;
    logic sync_d;
    logic sync_q;
    logic bkpt_d;
    logic bkpt_q;

    logic sw_rst_d;
    logic sw_rst_q;
    logic bkpt_sel_d;
    logic bkpt_sel_q;
    logic [`RSC_DATA_W-1:0] rdata_d;
    logic [`RSC_DATA_W-1:0] rdata_q;

    // All pin straps cross as one bundle; each bit filtered by agreement
    assign straps_raw = strap_pins;

    rsc_pin_sync #(
        .W(SW)
    ) u_strap_sync (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .din(straps_raw),
        .dout(straps)
    );

    rsc_pin_sync #(
        .W(2)
    ) u_misc_sync (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .din({ext_reset_req_pin, osc_stable_in}),
        .dout(misc_sync)
    );

    assign ext_req = misc_sync[1];
    assign osc_ok = misc_sync[0];

    rsc_reset_timer #(
        .HOLD(RST_HOLD_CYCLES),
        .LEAD(`RSC_WKP_LEAD)
    ) u_timer (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .start(t_start),
        .active(t_active),
        .lead_hit(t_lead),
        .last(t_last)
    );

    // A new sequence only starts once the previous one has negated
    assign t_start = (phase_q == RSC_PH_RUN) && (ext_req || debug_reset_req || sw_rst_q);

    // Packages without the external bus tie boot bit 0 low
    always_comb begin
        boot_eff = straps.boot_select_strap;
        if (!HAS_EXT_BUS) begin
            boot_eff[0] = 1'b0;
        end
    end

    always_comb begin
        phase_d = phase_q;
        src_d = src_q;
        wkp_lat_d = wkp_lat_q;
        wkp_rsr_d = wkp_rsr_q;
        boot_lat_d = boot_lat_q;
        xtal_d = xtal_q;
        dbg_en_d = dbg_en_q;
        pull_d = pull_q;
        mode_d = mode_q;
        cfgw_d = cfgw_q;
        rst_out_d = t_active;
        trace0_d = trace0_q;
        if (trace0_q && osc_ok) begin
            trace0_d = 1'b0;
        end
        case (phase_q)
            RSC_PH_ASSERT: begin
                // Live strap drives the pads until the latch point at t_lead
                pull_d = straps.weak_pull_select_strap;
                if (t_lead) begin
                    wkp_lat_d = straps.weak_pull_select_strap;
                    boot_lat_d = boot_eff;
                    if (src_q != RSC_SRC_DBG && src_q != RSC_SRC_SWEXT) begin
                        wkp_rsr_d = straps.weak_pull_select_strap;
                    end
                    phase_d = RSC_PH_HELD;
                end
            end
            RSC_PH_HELD: begin
                pull_d = wkp_lat_q;
                if (t_last) begin
                    dbg_en_d = straps.debug_event_in;
                    if (LARGE_PKG && straps.reset_cfg_select) begin
                        xtal_d = 1'b1;
                    end else begin
                        xtal_d = straps.osc_ref_select_strap;
                    end
                    mode_d = rsc_boot_decode(boot_lat_q);
                    cfgw_d = boot_lat_q[0];
                    phase_d = RSC_PH_RUN;
                end
            end
            RSC_PH_RUN: begin
                // Later strap changes are ignored here
                pull_d = wkp_lat_q;
                if (t_start) begin
                    phase_d = RSC_PH_ASSERT;
                    if (ext_req) begin
                        src_d = RSC_SRC_EXT;
                    end else if (debug_reset_req) begin
                        src_d = RSC_SRC_DBG;
                    end else begin
                        src_d = RSC_SRC_SWEXT;
                    end
                end
            end
            default: begin
                phase_d = RSC_PH_ASSERT;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_q <= RSC_PH_ASSERT;
            src_q <= RSC_SRC_POR;
            wkp_lat_q <= `RSC_PULL_RST;
            wkp_rsr_q <= `RSC_PULL_RST;
            boot_lat_q <= '0;
            xtal_q <= `RSC_XTAL_RST;
            dbg_en_q <= `RSC_DBGEN_RST;
            pull_q <= `RSC_PULL_RST;
            mode_q <= RSC_BOOT_FLASH;
            cfgw_q <= 1'b0;
            rst_out_q <= 1'b1;
            trace0_q <= `RSC_TRACE0_RST;
        end else if (clk_en) begin
            phase_q <= phase_d;
            src_q <= src_d;
            wkp_lat_q <= wkp_lat_d;
            wkp_rsr_q <= wkp_rsr_d;
            boot_lat_q <= boot_lat_d;
            xtal_q <= xtal_d;
            dbg_en_q <= dbg_en_d;
            pull_q <= pull_d;
            mode_q <= mode_d;
            cfgw_q <= cfgw_d;
            rst_out_q <= rst_out_d;
            trace0_q <= trace0_d;
        end
    end

    // Debug event edges, honoured only outside reset with the port enabled
    always_comb begin
        evt_prev_d = straps.debug_event_in;
        sync_d = 1'b0;
        bkpt_d = 1'b0;
        if (phase_q == RSC_PH_RUN && dbg_en_q) begin
            if (straps.debug_event_in && !evt_prev_q) begin
                if (bkpt_sel_q) begin
                    bkpt_d = 1'b1;
                end else begin
                    sync_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            evt_prev_q <= 1'b0;
            sync_q <= 1'b0;
            bkpt_q <= 1'b0;
        end else if (clk_en) begin
            evt_prev_q <= evt_prev_d;
            sync_q <= sync_d;
            bkpt_q <= bkpt_d;
        end
    end

    // Register port: software reset request self-clears once taken
    always_comb begin
        sw_rst_d = sw_rst_q;
        bkpt_sel_d = bkpt_sel_q;
        rdata_d = '0;
        if (t_start) begin
            sw_rst_d = 1'b0;
        end
        if (wr_en && addr == `RSC_REG_CTRL) begin
            bkpt_sel_d = wr_data[`RSC_CT_BKPT];
            if (wr_data[`RSC_CT_SWRST]) begin
                sw_rst_d = 1'b1;
            end
        end
        if (rd_en) begin
            case (addr)
                `RSC_REG_STATUS: begin
                    rdata_d[`RSC_ST_BOOT0] = boot_lat_q[0];
                    rdata_d[`RSC_ST_BOOT1] = boot_lat_q[1];
                    rdata_d[`RSC_ST_WKP] = wkp_rsr_q;
                    rdata_d[`RSC_ST_XTAL] = xtal_q;
                    rdata_d[`RSC_ST_DBGEN] = dbg_en_q;
                    rdata_d[`RSC_ST_OSCOK] = osc_ok;
                    rdata_d[`RSC_ST_INRST] = t_active;
                end
                `RSC_REG_CTRL: begin
                    rdata_d[`RSC_CT_SWRST] = sw_rst_q;
                    rdata_d[`RSC_CT_BKPT] = bkpt_sel_q;
                end
                `RSC_REG_SOURCE: begin
                    rdata_d[`RSC_SRC_HI:`RSC_SRC_LO] = src_q;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sw_rst_q <= 1'b0;
            bkpt_sel_q <= 1'b0;
            rdata_q <= '0;
        end else if (clk_en) begin
            sw_rst_q <= sw_rst_d;
            bkpt_sel_q <= bkpt_sel_d;
            rdata_q <= rdata_d;
        end
    end

    assign rd_data = rdata_q;
    assign reset_output_pin = rst_out_q;
    assign osc_xtal_mode = xtal_q;
    assign boot_mode = mode_q;
    assign cfg_word_ext = cfgw_q;
    assign pad_pull_up = pull_q;
    assign debug_port_en = dbg_en_q;
    assign sync_msg_req = sync_q;
    assign breakpoint_req = bkpt_q;
    assign trace_msg0_out = trace0_q;
endmodule : rsc_top

// file: rsc_chk.sv
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_chk
    import rsc_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1,
    parameter bit HAS_EXT_BUS = 1'b1,
    parameter int RST_HOLD_CYCLES = 32
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input rsc_pkg::rsc_straps_s strap_pins,
    input wire logic ext_reset_req_pin,
    input wire logic osc_stable_in,
    input wire logic debug_reset_req,
    input wire logic [`RSC_ADDR_W-1:0] addr,
    input wire logic [`RSC_DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [`RSC_DATA_W-1:0] rd_data,
    input wire logic reset_output_pin,
    input wire logic osc_xtal_mode,
    input rsc_pkg::rsc_boot_e boot_mode,
    input wire logic cfg_word_ext,
    input wire logic pad_pull_up,
    input wire logic debug_port_en,
    input wire logic sync_msg_req,
    input wire logic breakpoint_req,
    input wire logic trace_msg0_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_release;
        $fell(reset_output_pin);
    endsequence
    sequence s_enter;
        !reset_output_pin ##1 reset_output_pin;
    endsequence

    a_osc_mode: assert property (s_release |-> osc_xtal_mode ==
        (strap_pins.osc_ref_select_strap | (LARGE_PKG & strap_pins.reset_cfg_select)))
        else $error("oscillator mode wrong after reset");
    a_boot_code: assert property (s_release |-> boot_mode == rsc_boot_e'(
        {HAS_EXT_BUS & strap_pins.boot_select_strap[0], strap_pins.boot_select_strap[1]}))
        else $error("boot mode wrong after reset");
    a_cfg_word: assert property (s_release |->
        cfg_word_ext == (HAS_EXT_BUS & strap_pins.boot_select_strap[0]))
        else $error("config word source wrong");
    a_pull_dir: assert property (s_release |->
        pad_pull_up == strap_pins.weak_pull_select_strap)
        else $error("pad pull direction wrong");
    a_cfg_hold: assert property (!reset_output_pin && !$past(reset_output_pin) |->
        $stable({osc_xtal_mode, boot_mode, cfg_word_ext, pad_pull_up, debug_port_en}))
        else $error("latched configuration moved outside reset");
    a_trace_once: assert property (!$past(trace_msg0_out) |-> !trace_msg0_out)
        else $error("trace bit rose again");
    a_event_pulse: assert property ((sync_msg_req || breakpoint_req) |=>
        !(sync_msg_req || breakpoint_req))
        else $error("debug event request longer than one cycle");
    a_event_gate: assert property ((sync_msg_req || breakpoint_req) |->
        $past(debug_port_en))
        else $error("debug event request while port disabled");
    a_out_hold: assert property (s_enter |-> reset_output_pin[*8])
        else $error("reset output too short");
    a_rd_idle: assert property (!$past(rd_en) |-> rd_data == '0)
        else $error("read data outside read cycle");
endmodule : rsc_chk

bind rsc_top rsc_chk #(.LARGE_PKG(LARGE_PKG), .HAS_EXT_BUS(HAS_EXT_BUS),
    .RST_HOLD_CYCLES(RST_HOLD_CYCLES)) i_chk (
    .clk(clk), .reset(reset), .clk_en(clk_en), .strap_pins(strap_pins),
    .ext_reset_req_pin(ext_reset_req_pin), .osc_stable_in(osc_stable_in),
    .debug_reset_req(debug_reset_req), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .reset_output_pin(reset_output_pin),
    .osc_xtal_mode(osc_xtal_mode), .boot_mode(boot_mode), .cfg_word_ext(cfg_word_ext),
    .pad_pull_up(pad_pull_up), .debug_port_en(debug_port_en), .sync_msg_req(sync_msg_req),
    .breakpoint_req(breakpoint_req), .trace_msg0_out(trace_msg0_out));

// file: rsc_board_model.sv
`timescale 1ns/1ps
module rsc_board_model
    import rsc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic reset_output_pin,
    input rsc_pkg::rsc_straps_s want,
    input wire logic want_ext,
    input wire logic want_osc,
    output rsc_pkg::rsc_straps_s strap_pins,
    output logic ext_reset_req_pin,
    output logic osc_stable_in
);
    // Straps always driven to a level, frozen while the device samples
    always @(posedge clk) begin
        if (reset || !reset_output_pin) begin
            strap_pins <= want;
        end
        ext_reset_req_pin <= want_ext;
        osc_stable_in <= want_osc;
    end
endmodule : rsc_board_model

// file: rsc_top_tb_top.sv
`timescale 1ns/1ps
module rsc_top_tb_top;
    import rsc_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic debug_reset_req = 1'b0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic want_ext = 1'b0;
    logic want_osc = 1'b0;
    rsc_straps_s want = 6'h1D;
    rsc_straps_s strap_pins;
    logic ext_reset_req_pin, osc_stable_in, reset_output_pin, osc_xtal_mode, cfg_word_ext;
    logic pad_pull_up, debug_port_en, sync_msg_req, breakpoint_req, trace_msg0_out;
    logic [31:0] rd_data;
    rsc_boot_e boot_mode;
    int failures = 0;
    int num_checks = 0;
    int i;

    always #5 clk = ~clk;

    // Hold must outlast the strap synchroniser before the pull latch point
    rsc_top #(.LARGE_PKG(1'b1), .HAS_EXT_BUS(1'b1), .RST_HOLD_CYCLES(16)) i_dut (
        .clk(clk), .reset(reset), .clk_en(1'b1), .strap_pins(strap_pins),
        .ext_reset_req_pin(ext_reset_req_pin), .osc_stable_in(osc_stable_in),
        .debug_reset_req(debug_reset_req), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .reset_output_pin(reset_output_pin),
        .osc_xtal_mode(osc_xtal_mode), .boot_mode(boot_mode), .cfg_word_ext(cfg_word_ext),
        .pad_pull_up(pad_pull_up), .debug_port_en(debug_port_en),
        .sync_msg_req(sync_msg_req), .breakpoint_req(breakpoint_req),
        .trace_msg0_out(trace_msg0_out));

    rsc_board_model i_board (.clk(clk), .reset(reset), .reset_output_pin(reset_output_pin),
        .want(want), .want_ext(want_ext), .want_osc(want_osc), .strap_pins(strap_pins),
        .ext_reset_req_pin(ext_reset_req_pin), .osc_stable_in(osc_stable_in));

    task automatic end_of_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        check(rd_data, exp);
    endtask : rd

    task automatic wait_for(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 300) begin
                failures++;
                end_of_test();
            end
        end
    endtask : wait_for

    // Kind 1 external pin, 2 debug port, 3 software
    task automatic do_reset(input int kind);
        if (kind == 3) begin
            wr(8'h04, 32'h1);
        end else begin
            @(posedge clk);
            want_ext <= (kind == 1);
            debug_reset_req <= (kind == 2);
            @(posedge clk);
            debug_reset_req <= 1'b0;
        end
        wait_for(reset_output_pin, 1'b1);
        @(posedge clk);
        want_ext <= 1'b0;
        wait_for(reset_output_pin, 1'b0);
    endtask : do_reset

    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        wait_for(reset_output_pin, 1'b0);
        check(osc_xtal_mode, 1'b1);
        check(boot_mode, RSC_BOOT_EXTMEM);
        check(cfg_word_ext, 1'b1);
        check(pad_pull_up, 1'b1);
        check(debug_port_en, 1'b1);
        check(trace_msg0_out, 1'b1);
        @(posedge clk);
        want_osc <= 1'b1;
        wait_for(trace_msg0_out, 1'b0);
        rd(8'h00, 32'h3D);
        rd(8'h08, 32'h0);
        rd(8'h0C, 32'h0);
        wr(8'h00, 32'hFFFFFFFF);
        rd(8'h00, 32'h3D);
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            want.boot_select_strap <= i[1:0];
            want.osc_ref_select_strap <= i[0];
            want.reset_cfg_select <= 1'b0;
            want.weak_pull_select_strap <= i[1];
            do_reset(1);
            check(boot_mode, i[1:0]);
            check(osc_xtal_mode, i[0]);
            check(cfg_word_ext, i[1]);
            check(pad_pull_up, i[1]);
            rd(8'h00, {26'h0, 2'b11, i[0], i[1], i[0], i[1]});
            rd(8'h08, 32'h1);
        end
        // Stored pull copy must survive debug and software resets
        @(posedge clk);
        want.weak_pull_select_strap <= 1'b0;
        do_reset(2);
        check(pad_pull_up, 1'b0);
        rd(8'h00, 32'h3F);
        rd(8'h08, 32'h2);
        do_reset(3);
        rd(8'h00, 32'h3F);
        rd(8'h08, 32'h3);
        @(posedge clk);
        want.debug_event_in <= 1'b0;
        repeat (6) @(posedge clk);
        want.debug_event_in <= 1'b1;
        wait_for(sync_msg_req, 1'b1);
        check(breakpoint_req, 1'b0);
        wr(8'h04, 32'h2);
        want.debug_event_in <= 1'b0;
        repeat (6) @(posedge clk);
        want.debug_event_in <= 1'b1;
        wait_for(breakpoint_req, 1'b1);
        check(sync_msg_req, 1'b0);
        @(posedge clk);
        want <= 6'h00;
        repeat (10) @(posedge clk);
        #1;
        check({osc_xtal_mode, boot_mode, pad_pull_up, debug_port_en},
              {1'b1, RSC_BOOT_RSVD, 1'b0, 1'b1});
        end_of_test();
    end
endmodule : rsc_top_tb_top
